// >>> hw/global_config_register_bank.sv
// Overview of operation
// - Unimplemented chip-level registers and bits ignore writes and read zero.
// - Index port picks the register; data port reads or writes it.
// - Registers respond only while the configuration state is active.
// - Writing one to bit 0 of 0x02 soft-resets every register except the index.
// - The soft-reset bit clears itself; software never writes zero.
// - Writing 0x07 chooses the current logical device.
// - Activate acts only on the selected logical device.
// - Read-only hard-wired identification byte at 0x20.
// - Read-only hard-wired revision byte at 0x21.
// - Reserved indices 0x04-0x06 and 0x08-0x1F ignore writes, read zero.
// - Power bits 0,3,4,5 enable floppy, parallel, serial one, serial two.
// - Power management uses the same bit positions and meanings.
// - Bits 1-2 and 6-7 of both power registers read zero.
// - Oscillator 00 runs always; 11 stops oscillator and baud clock.
// - Oscillator 01 or 10 runs only while power good is active.
// - Bits 6-4 choose clock output; 101 and 11x reserved.
// - Bit 7 sets irq8 pin polarity: zero high, one low.
// - Same polarity applies to the serial interrupt IRQ8 sample level.
// - Device mode bits 4-3 choose floppy-on-parallel mode; 11 reserved.
// - Device mode bits 1-0 and 7-5 ignore writes, read zero.
// - Activate bit 0 enables the selected logical device.
// - Serial interrupt mode is device mode bit 2, driven out as is; the irq8 pin does not depend on it.
// - Each logical device has its own bank chosen by the selector.
`timescale 1ns/10ps
`include "global_cfg_defines.svh"

module global_config_register_bank #(
    parameter int NUM_LDEV = 10,
    parameter logic [7:0] CHIP_ID_VALUE = 8'hA5, // Arbitrary value
    parameter logic [7:0] CHIP_REV_VALUE = 8'h5A // Arbitrary value
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Host configuration port
    input wire logic config_state_i,
    input wire global_cfg_pkg::host_req_t req_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    // Pins from outside
    input wire logic power_good_input_i,
    input wire logic irq8_request_i,
    // Control outputs
    output logic [7:0] ldev_select_o,
    output logic [NUM_LDEV-1:0] ldev_active_o,
    output global_cfg_pkg::func_en_t power_enable_o,
    output global_cfg_pkg::func_en_t power_mgmt_o,
    output logic oscillator_run_o,
    output logic baud_rate_generator_clock_en_o,
    output global_cfg_pkg::clk_out_sel_t clk_out_sel_o,
    output logic irq8_output_pin_o,
    output logic irq8_serial_sample_o,
    output logic serial_interrupt_mode_o,
    output logic floppy_on_parallel_one_drive_o,
    output logic floppy_on_parallel_two_drive_o,
    output logic soft_reset_pulse_o
);
    import global_cfg_pkg::*;

    // =================================================================
    // State
    typedef struct packed {
        logic [7:0] index;
        logic [7:0] ldev;
        logic [NUM_LDEV-1:0] active;
        logic [7:0] pwr_en;
        logic [7:0] pwr_mgmt;
        logic [7:0] osc;
        logic [7:0] mode;
        logic [1:0] pg_sync;
        logic [1:0] irq_sync;
        logic [7:0] rdata;
        logic rvalid;
        logic soft_rst;
        logic osc_run;
        logic irq8_pin;
        logic irq8_ser;
        logic ppfd_one;
        logic ppfd_two;
    } state_t;

    state_t state_q;
    state_t state_d;
    logic [7:0] read_mux;
    logic power_good;
    logic irq8_req;

    // Second stage of each synchroniser is the only reader of the first
    assign power_good = state_q.pg_sync[1];
    assign irq8_req = state_q.irq_sync[1];

    // =================================================================
    // Read multiplexer, zero for anything unmapped
    always_comb begin
        read_mux = 8'h00;
        case (state_q.index)
            `IDX_LDEV_SELECT: read_mux = state_q.ldev;
            `IDX_CHIP_ID: read_mux = CHIP_ID_VALUE;
            `IDX_CHIP_REV: read_mux = CHIP_REV_VALUE;
            `IDX_PWR_ENABLE: read_mux = state_q.pwr_en & `MASK_PWR;
            `IDX_PWR_MGMT: read_mux = state_q.pwr_mgmt & `MASK_PWR;
            `IDX_OSC_CLKOUT: read_mux = state_q.osc & `MASK_OSC;
            `IDX_DEV_MODE: read_mux = state_q.mode & `MASK_DEV_MODE;
            `IDX_ACTIVATE: begin
                // Activate bit of the bank the selector names
                if (state_q.ldev < 8'(NUM_LDEV)) begin
                    read_mux = {7'h00, state_q.active[state_q.ldev[3:0]]};
                end
            end
            default: read_mux = 8'h00;
        endcase
    end

    // =================================================================
    // Next-state logic
    always_comb begin
        state_d = state_q;
        state_d.pg_sync = {state_q.pg_sync[0], power_good_input_i};
        state_d.irq_sync = {state_q.irq_sync[0], irq8_request_i};
        state_d.soft_rst = 1'b0;
        state_d.rvalid = 1'b0;
        // Outside configuration state the port is deaf
        if (config_state_i) begin
            if (req_i.index_wr) begin
                state_d.index = req_i.wdata;
            end
            if (req_i.data_rd) begin
                state_d.rdata = read_mux;
                state_d.rvalid = 1'b1;
            end
            if (req_i.data_wr) begin
                case (state_q.index)
                    `IDX_CONFIG_CONTROL: begin
                        state_d.soft_rst = req_i.wdata[`BIT_SOFT_RESET];
                    end
                    `IDX_LDEV_SELECT: state_d.ldev = req_i.wdata;
                    `IDX_PWR_ENABLE: state_d.pwr_en = req_i.wdata & `MASK_PWR;
                    `IDX_PWR_MGMT: state_d.pwr_mgmt = req_i.wdata & `MASK_PWR;
                    `IDX_OSC_CLKOUT: state_d.osc = req_i.wdata & `MASK_OSC;
                    `IDX_DEV_MODE: state_d.mode = req_i.wdata & `MASK_DEV_MODE;
                    `IDX_ACTIVATE: begin
                        // Only the selected device changes
                        if (state_q.ldev < 8'(NUM_LDEV)) begin
                            state_d.active[state_q.ldev[3:0]] = req_i.wdata[0];
                        end
                    end
                    default: begin
                        // Reserved and read-only: write discarded
                    end
                endcase
            end
        end
        // Soft reset reloads defaults, the selector included; only the index survives
        if (state_q.soft_rst) begin
            state_d.ldev = `RST_LDEV;
            state_d.active = '0;
            state_d.pwr_en = `RST_PWR;
            state_d.pwr_mgmt = `RST_PWR;
            state_d.osc = `RST_OSC;
            state_d.mode = `RST_DEV_MODE;
        end
        // Oscillator run decode
        case (state_q.osc[`OSC_HI:`OSC_LO])
            `OSC_ALWAYS_ON: state_d.osc_run = 1'b1;
            `OSC_OFF: state_d.osc_run = 1'b0;
            default: state_d.osc_run = power_good;
        endcase
        // Polarity applied to both the pin and the serial sample
        state_d.irq8_pin = irq8_req ^ state_q.osc[`BIT_IRQ8_POL];
        state_d.irq8_ser = irq8_req ^ state_q.osc[`BIT_IRQ8_POL];
        // Floppy-on-parallel decode is registered so the outputs come from flops
        state_d.ppfd_one = (state_q.mode[`PPFD_HI:`PPFD_LO] == `PPFD_ONE);
        state_d.ppfd_two = (state_q.mode[`PPFD_HI:`PPFD_LO] == `PPFD_TWO);
    end

    // =================================================================
    // State register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= '0;
            state_q.ldev <= `RST_LDEV;
            state_q.pwr_en <= `RST_PWR;
            state_q.pwr_mgmt <= `RST_PWR;
            state_q.osc <= `RST_OSC;
            state_q.mode <= `RST_DEV_MODE;
        end else begin
            state_q <= state_d;
        end
    end

    // =================================================================
    // Outputs, all straight from flip-flops
    assign rdata_o = state_q.rdata;
    assign rvalid_o = state_q.rvalid;
    assign ldev_select_o = state_q.ldev;
    assign ldev_active_o = state_q.active;
    assign power_enable_o = func_en_t'({state_q.pwr_en[`BIT_PWR_FLOPPY],
        state_q.pwr_en[`BIT_PWR_PARALLEL], state_q.pwr_en[`BIT_PWR_SERIAL1],
        state_q.pwr_en[`BIT_PWR_SERIAL2]});
    assign power_mgmt_o = func_en_t'({state_q.pwr_mgmt[`BIT_PWR_FLOPPY],
        state_q.pwr_mgmt[`BIT_PWR_PARALLEL], state_q.pwr_mgmt[`BIT_PWR_SERIAL1],
        state_q.pwr_mgmt[`BIT_PWR_SERIAL2]});
    assign oscillator_run_o = state_q.osc_run;
    assign baud_rate_generator_clock_en_o = state_q.osc_run;
    // Reserved clock codes pass through unchanged to clk_out_sel_o
    assign clk_out_sel_o = clk_out_sel_t'(state_q.osc[`CLKSEL_HI:`CLKSEL_LO]);
    assign irq8_output_pin_o = state_q.irq8_pin;
    assign irq8_serial_sample_o = state_q.irq8_ser;
    assign serial_interrupt_mode_o = state_q.mode[`BIT_SIRQ_MODE];
    assign floppy_on_parallel_one_drive_o = state_q.ppfd_one;
    assign floppy_on_parallel_two_drive_o = state_q.ppfd_two;
    assign soft_reset_pulse_o = state_q.soft_rst;

    // =================================================================
    // Checks
    sequence soft_rst_write_s;
        config_state_i && req_i.data_wr && state_q.index == `IDX_CONFIG_CONTROL
            && req_i.wdata[0];
    endsequence

    soft_reset_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        soft_rst_write_s |=> ##1 (state_q.pwr_en == `RST_PWR && state_q.osc == `RST_OSC))
        else $error("soft reset did not restore defaults");

    soft_bit_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        soft_reset_pulse_o |=> !soft_reset_pulse_o)
        else $error("soft reset bit did not self clear");

    deaf_outside_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !config_state_i |=> !rvalid_o && $stable(state_q.index))
        else $error("access taken outside configuration state");

    id_readback_a: assert property (@(posedge clk_i) disable iff (rst_i)
        config_state_i && req_i.data_rd && state_q.index == `IDX_CHIP_ID
            |=> rdata_o == CHIP_ID_VALUE)
        else $error("identification byte wrong");

    rev_readback_a: assert property (@(posedge clk_i) disable iff (rst_i)
        config_state_i && req_i.data_rd && state_q.index == `IDX_CHIP_REV
            |=> rdata_o == CHIP_REV_VALUE)
        else $error("revision byte wrong");
    reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        config_state_i && req_i.data_rd && state_q.index >= 8'h08 && state_q.index <= 8'h1F
            |=> rdata_o == 8'h00)
        else $error("reserved index read nonzero");
    power_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q.pwr_en & ~`MASK_PWR) == 8'h00 && (state_q.pwr_mgmt & ~`MASK_PWR) == 8'h00)
        else $error("reserved power bits set");
    osc_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q.osc[`OSC_HI:`OSC_LO] == `OSC_OFF) [*2] |-> !oscillator_run_o)
        else $error("oscillator runs in off code");
    irq8_polarity_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $stable(state_q.osc[7]) |=> irq8_output_pin_o == ($past(irq8_req) ^ $past(state_q.osc[7])))
        else $error("irq8 polarity wrong");
    ldev_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        config_state_i && req_i.data_wr && state_q.index == `IDX_LDEV_SELECT && !soft_reset_pulse_o
            |=> ldev_select_o == $past(req_i.wdata))
        else $error("logical device select not stored");

    // =================================================================
    // Host strobes as seen by the bank; the port is deaf outside the state
    sequence host_wr_s;
        config_state_i && req_i.data_wr;
    endsequence

    sequence host_rd_s;
        config_state_i && req_i.data_rd;
    endsequence

    // Index register takes the byte written to the index port
    index_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        config_state_i && req_i.index_wr |=> state_q.index == $past(req_i.wdata))
        else $error("index not stored");

    // Every accepted read answers on the next edge
    read_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
        host_rd_s |=> rvalid_o)
        else $error("read not answered");

    // Indices above the mode register, apart from activate, read zero
    unmapped_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        host_rd_s ##0 (state_q.index > `IDX_DEV_MODE && state_q.index != `IDX_ACTIVATE)
            |=> rdata_o == 8'h00)
        else $error("unmapped index read nonzero");

    // Power enable keeps only its four function bits
    pwr_en_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        host_wr_s ##0 (state_q.index == `IDX_PWR_ENABLE && !state_q.soft_rst)
            |=> state_q.pwr_en == ($past(req_i.wdata) & `MASK_PWR))
        else $error("power enable not stored");

    // Power management mirrors the same layout
    pwr_mgmt_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        host_wr_s ##0 (state_q.index == `IDX_PWR_MGMT && !state_q.soft_rst)
            |=> state_q.pwr_mgmt == ($past(req_i.wdata) & `MASK_PWR))
        else $error("power management not stored");

    // Mode register keeps only bits 4 to 2
    mode_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        host_wr_s ##0 (state_q.index == `IDX_DEV_MODE && !state_q.soft_rst)
            |=> state_q.mode == ($past(req_i.wdata) & `MASK_DEV_MODE))
        else $error("device mode not stored");

    // Reserved oscillator and mode bits never hold a one
    osc_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q.osc & ~`MASK_OSC) == 8'h00)
        else $error("reserved oscillator bits set");

    mode_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q.mode & ~`MASK_DEV_MODE) == 8'h00)
        else $error("reserved mode bits set");

    // Code 00 keeps the oscillator running regardless of power good
    osc_always_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q.osc[`OSC_HI:`OSC_LO] == `OSC_ALWAYS_ON |=> oscillator_run_o)
        else $error("oscillator stopped in always-on code");

    // Codes 01 and 10 follow the synchronised power good one edge later
    osc_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q.osc[`OSC_HI:`OSC_LO] != `OSC_ALWAYS_ON
            && state_q.osc[`OSC_HI:`OSC_LO] != `OSC_OFF
            |=> oscillator_run_o == $past(power_good))
        else $error("oscillator ignores power good");

    // Baud clock enable is the same flop decode as the oscillator
    brg_match_a: assert property (@(posedge clk_i) disable iff (rst_i)
        baud_rate_generator_clock_en_o == oscillator_run_o)
        else $error("baud clock enable differs from oscillator");

    // Pin and serial frame sample must never disagree
    irq8_serial_a: assert property (@(posedge clk_i) disable iff (rst_i)
        irq8_serial_sample_o == irq8_output_pin_o)
        else $error("serial irq8 sample differs from pin");

    // A soft-reset write raises the pulse on the next edge
    soft_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        host_wr_s ##0 (state_q.index == `IDX_CONFIG_CONTROL
            && req_i.wdata[`BIT_SOFT_RESET]) |=> soft_reset_pulse_o)
        else $error("soft reset pulse missing");

    // Activate bits move only on an activate write or a soft reset
    activate_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !(config_state_i && req_i.data_wr && state_q.index == `IDX_ACTIVATE)
            && !state_q.soft_rst |=> $stable(state_q.active))
        else $error("activate bits changed without a write");

    // One and two drive modes are exclusive
    ppfd_exclusive_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !(floppy_on_parallel_one_drive_o && floppy_on_parallel_two_drive_o))
        else $error("both floppy-on-parallel modes set");

    // Serial interrupt mode comes straight from its stored bit
    sirq_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
        serial_interrupt_mode_o == state_q.mode[`BIT_SIRQ_MODE])
        else $error("serial interrupt mode wrong");

    // Clock select is the stored field; reserved codes pass unchanged
    clk_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
        3'(clk_out_sel_o) == state_q.osc[`CLKSEL_HI:`CLKSEL_LO])
        else $error("clock select wrong");

    // Activate read returns the bit of the device the selector names
    activate_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        host_rd_s ##0 (state_q.index == `IDX_ACTIVATE && state_q.ldev < 8'(NUM_LDEV))
            |=> rdata_o[0] == $past(state_q.active[state_q.ldev[3:0]]))
        else $error("activate read wrong");

    // Activate write lands on the selected device only
    activate_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        host_wr_s ##0 (state_q.index == `IDX_ACTIVATE && state_q.ldev < 8'(NUM_LDEV)
            && !state_q.soft_rst)
            |=> state_q.active[$past(state_q.ldev[3:0])] == $past(req_i.wdata[0]))
        else $error("activate write lost");

endmodule // global_config_register_bank

// >>> hw/global_cfg_defines.svh
`ifndef GLOBAL_CFG_DEFINES_SVH
`define GLOBAL_CFG_DEFINES_SVH

// =====================================================================
// Register indices
`define IDX_CONFIG_CONTROL 8'h02
`define IDX_LDEV_SELECT 8'h07
`define IDX_CHIP_ID 8'h20
`define IDX_CHIP_REV 8'h21
`define IDX_PWR_ENABLE 8'h22
`define IDX_PWR_MGMT 8'h23
`define IDX_OSC_CLKOUT 8'h24
`define IDX_DEV_MODE 8'h25
`define IDX_ACTIVATE 8'h30

// =====================================================================
// Writable bit masks
`define MASK_PWR 8'h39
`define MASK_OSC 8'hFC
`define MASK_DEV_MODE 8'h1C
`define MASK_ACTIVATE 8'h01

// =====================================================================
// Reset values
`define RST_LDEV 8'h00
`define RST_PWR 8'h00
`define RST_OSC 8'h04
`define RST_DEV_MODE 8'h04
`define RST_ACTIVATE 1'b0

// =====================================================================
// Field positions
`define BIT_SOFT_RESET 0
`define BIT_PWR_FLOPPY 0
`define BIT_PWR_PARALLEL 3
`define BIT_PWR_SERIAL1 4
`define BIT_PWR_SERIAL2 5
`define OSC_LO 2
`define OSC_HI 3
`define CLKSEL_LO 4
`define CLKSEL_HI 6
`define BIT_IRQ8_POL 7
`define BIT_SIRQ_MODE 2
`define PPFD_LO 3
`define PPFD_HI 4

// =====================================================================
// Field codes
`define OSC_ALWAYS_ON 2'b00
`define OSC_OFF 2'b11
`define PPFD_ONE 2'b01
`define PPFD_TWO 2'b10

`endif

// >>> hw/global_cfg_pkg.sv
package global_cfg_pkg;
    // Host access strobes
    typedef struct packed {
        logic       index_wr;
        logic       data_wr;
        logic       data_rd;
        logic [7:0] wdata;
    } host_req_t;

    // Clock output choices
    typedef enum logic [2:0] {
        CLK_1M8432 = 3'b000,
        CLK_14M318 = 3'b001,
        CLK_16M = 3'b010,
        CLK_24M = 3'b011,
        CLK_48M = 3'b100
    } clk_out_sel_t;

    // Per-function enables
    typedef struct packed {
        logic floppy_controller;
        logic parallel;
        logic serial1;
        logic serial2;
    } func_en_t;
endpackage

// >>> verif/tb_global_config_register_bank.sv
`timescale 1ns/10ps
`include "global_cfg_defines.svh"

module tb_global_config_register_bank;
    import global_cfg_pkg::*;

    // ==========================================================
    // Signals and design
    localparam logic [7:0] ID_V = 8'h3C; // Arbitrary value
    localparam logic [7:0] REV_V = 8'hC3; // Arbitrary value
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic config_state_i = 1'b1;
    host_req_t req_i = '0;
    logic power_good_input_i = 1'b1;
    logic irq8_request_i = 1'b0;
    logic [7:0] rdata_o, ldev_select_o;
    logic [9:0] ldev_active_o;
    func_en_t power_enable_o, power_mgmt_o;
    logic oscillator_run_o, baud_rate_generator_clock_en_o, irq8_output_pin_o;
    logic irq8_serial_sample_o, serial_interrupt_mode_o, rvalid_o, soft_reset_pulse_o;
    logic floppy_on_parallel_one_drive_o, floppy_on_parallel_two_drive_o;
    clk_out_sel_t clk_out_sel_o;
    logic [7:0] exp_q[$];
    int bad_count = 0;
    int checks = 0;
    int pulses = 0;
    logic [7:0] r, p;
    logic e;

    // 20 MHz clock
    always #25 clk_i = ~clk_i;

    global_config_register_bank #(.NUM_LDEV(10), .CHIP_ID_VALUE(ID_V),
        .CHIP_REV_VALUE(REV_V)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .config_state_i(config_state_i), .req_i(req_i), .rdata_o(rdata_o),
        .rvalid_o(rvalid_o), .power_good_input_i(power_good_input_i),
        .irq8_request_i(irq8_request_i), .ldev_select_o(ldev_select_o),
        .ldev_active_o(ldev_active_o), .power_enable_o(power_enable_o),
        .power_mgmt_o(power_mgmt_o), .oscillator_run_o(oscillator_run_o),
        .baud_rate_generator_clock_en_o(baud_rate_generator_clock_en_o),
        .clk_out_sel_o(clk_out_sel_o), .irq8_output_pin_o(irq8_output_pin_o),
        .irq8_serial_sample_o(irq8_serial_sample_o),
        .serial_interrupt_mode_o(serial_interrupt_mode_o),
        .floppy_on_parallel_one_drive_o(floppy_on_parallel_one_drive_o),
        .floppy_on_parallel_two_drive_o(floppy_on_parallel_two_drive_o),
        .soft_reset_pulse_o(soft_reset_pulse_o));

    // ==========================================================
    // Tasks
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One request per falling edge, so a strobe lasts exactly one cycle
    task automatic acc(input logic iw, input logic dw, input logic dr, input logic [7:0] d);
        @(negedge clk_i);
        req_i <= {iw, dw, dr, d};
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        acc(1'b1, 1'b0, 1'b0, idx);
        acc(1'b0, 1'b1, 1'b0, d);
        acc(1'b0, 1'b0, 1'b0, 8'h00);
    endtask

    // Outside configuration state no answer is expected at all
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        acc(1'b1, 1'b0, 1'b0, idx);
        if (config_state_i) exp_q.push_back(exp);
        acc(1'b0, 1'b0, 1'b1, 8'h00);
        acc(1'b0, 1'b0, 1'b0, 8'h00);
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Output monitor: read answers pop the oldest note
    always @(negedge clk_i) begin
        if (soft_reset_pulse_o === 1'b1) pulses++;
        if (rvalid_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                bad_count++;
                $display("wrong value at %0t: read answer with none expected", $time);
            end else begin
                cmp(rdata_o, exp_q.pop_front());
            end
        end
    end

    // Watchdog, well past the expected run of about 800 cycles
    initial begin
        repeat (8000) @(posedge clk_i);
        bad_count++;
        conclude();
    end

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(6883));
        repeat (20) @(negedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(negedge clk_i);
        cmp({7'h00, serial_interrupt_mode_o}, 8'h01);
        cmp({7'h00, oscillator_run_o}, 8'h01);
        cmp({5'h00, clk_out_sel_o}, 8'h00);
        rd(`IDX_LDEV_SELECT, 8'h00);
        rd(`IDX_PWR_ENABLE, 8'h00);
        rd(`IDX_OSC_CLKOUT, 8'h04);
        rd(`IDX_DEV_MODE, 8'h04);
        wr(`IDX_CHIP_ID, 8'hFF);
        wr(`IDX_CHIP_REV, 8'h00);
        rd(`IDX_CHIP_ID, ID_V);
        rd(`IDX_CHIP_REV, REV_V);
        // Reserved indices swallow writes
        for (int i = 0; i < 32; i++) begin
            if (i != 2 && i != 7) begin
                wr(8'(i), 8'hFF);
                rd(8'(i), 8'h00);
            end
        end
        // Power registers with random patterns
        repeat (4) begin
            r = 8'($urandom);
            wr(`IDX_PWR_ENABLE, r);
            wr(`IDX_PWR_MGMT, ~r);
            rd(`IDX_PWR_ENABLE, r & `MASK_PWR);
            rd(`IDX_PWR_MGMT, ~r & `MASK_PWR);
            cmp({4'h0, power_enable_o}, {4'h0, r[0], r[3], r[4], r[5]});
            cmp({4'h0, power_mgmt_o}, {4'h0, ~r[0], ~r[3], ~r[4], ~r[5]});
        end
        p = r & `MASK_PWR;
        // Every oscillator code, clock select and polarity
        for (int i = 0; i < 40; i++) begin
            r = {i >= 20, 3'((i / 4) % 5), 2'(i % 4), 2'b11};
            power_good_input_i <= 1'($urandom);
            irq8_request_i <= 1'($urandom);
            wr(`IDX_OSC_CLKOUT, r);
            repeat (4) @(negedge clk_i);
            e = (r[3:2] == 2'b00) || (r[3:2] != 2'b11 && power_good_input_i);
            rd(`IDX_OSC_CLKOUT, r & `MASK_OSC);
            cmp({5'h00, clk_out_sel_o}, {5'h00, r[6:4]});
            cmp({7'h00, oscillator_run_o}, {7'h00, e});
            cmp({7'h00, baud_rate_generator_clock_en_o}, {7'h00, e});
            cmp({7'h00, irq8_output_pin_o}, {7'h00, irq8_request_i ^ r[7]});
            cmp({7'h00, irq8_serial_sample_o}, {7'h00, irq8_request_i ^ r[7]});
        end
        // Device mode codes with reserved bits set
        for (int i = 0; i < 6; i++) begin
            r = {3'b111, 2'(i % 3), 1'(i / 3), 2'b11};
            wr(`IDX_DEV_MODE, r);
            rd(`IDX_DEV_MODE, r & `MASK_DEV_MODE);
            cmp({7'h00, serial_interrupt_mode_o}, {7'h00, r[2]});
            cmp({6'h00, floppy_on_parallel_two_drive_o, floppy_on_parallel_one_drive_o},
                {6'h00, r[4:3]});
        end
        // Activate lands only on the selected device
        wr(`IDX_LDEV_SELECT, 8'h02);
        wr(`IDX_ACTIVATE, 8'hFF);
        wr(`IDX_LDEV_SELECT, 8'h09);
        wr(`IDX_ACTIVATE, 8'h01);
        wr(`IDX_LDEV_SELECT, 8'h02);
        wr(`IDX_ACTIVATE, 8'h00);
        rd(`IDX_LDEV_SELECT, 8'h02);
        cmp(ldev_select_o, 8'h02);
        cmp(ldev_active_o[9:2], 8'h80);
        cmp({6'h00, ldev_active_o[1:0]}, 8'h00);
        wr(`IDX_LDEV_SELECT, 8'h09);
        rd(`IDX_ACTIVATE, 8'h01);
        // Outside configuration state nothing changes or answers
        config_state_i <= 1'b0;
        wr(`IDX_PWR_ENABLE, ~p);
        rd(`IDX_PWR_ENABLE, 8'h00);
        config_state_i <= 1'b1;
        rd(`IDX_PWR_ENABLE, p);
        // Soft reset restores defaults and clears itself
        wr(`IDX_CONFIG_CONTROL, 8'h01);
        repeat (2) @(negedge clk_i);
        cmp({7'h00, soft_reset_pulse_o}, 8'h00);
        cmp(8'(pulses), 8'h01);
        cmp(ldev_active_o[9:2], 8'h00);
        rd(`IDX_LDEV_SELECT, 8'h00);
        rd(`IDX_PWR_ENABLE, 8'h00);
        rd(`IDX_OSC_CLKOUT, 8'h04);
        rd(`IDX_DEV_MODE, 8'h04);
        repeat (5) @(negedge clk_i);
        cmp(8'(exp_q.size()), 8'h00);
        conclude();
    end
endmodule // tb_global_config_register_bank
